// [rtl/cpi2c_pkg.sv]
// Constants and types for the control port in I2C slave mode.
// Assumes every user writes cpi2c_pkg::name; nothing is imported.
package cpi2c_pkg;
  // ==========================================================
  // Widths and depths
  localparam int BYTE_W     = 8;
  localparam int ADDR_W     = 7;
  localparam int FIFO_DEPTH = 4;
  localparam int VEC_W      = 16;

  // ==========================================================
  // Bit counts, vectors, reset values
  localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
  localparam logic [3:0]  LAST_BIT_BEFORE  = 4'h7;
  localparam logic [3:0]  CNT_ZERO         = 4'h0;
  localparam logic [3:0]  CNT_ONE          = 4'h1;
  localparam logic [15:0] VEC_INPUT_FULL   = 16'h0006;
  localparam logic [15:0] VEC_OUTPUT_EMPTY = 16'h0007;
  localparam logic [15:0] VEC_NONE         = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [6:0]  ADDR_ZERO        = 7'h00;
  localparam logic        MODE_I2C         = 1'b0;
  localparam logic [1:0]  MODE_LOAD_WAIT   = 2'h2;
  localparam logic [1:0]  MODE_LOAD_DONE   = 2'h0;

  // ==========================================================
  // Protocol states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_DATA  = 3'b011,
    ST_WR_ACK   = 3'b100,
    ST_RD_DATA  = 3'b101,
    ST_RD_ACK   = 3'b110
  } cpi2c_state_t;
endpackage : cpi2c_pkg

// [rtl/cpi2c_control_port.sv]
// Control port slave for the I2C-compatible mode, plus its output FIFO.
// Assumes one 50 MHz clock; serial pins are asynchronous and get
// synchronised here; DSP-side strobes are on the core clock.
`timescale 1ns/10ps

// ============================================================
// Output FIFO between DSP writes and the output holding register
module cpi2c_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,      // Core clock
  input  wire logic             rst_n_i,    // Synchronised reset
  input  wire logic             in_valid_i, // Write request
  output logic                  in_ready_o, // Room available
  input  wire logic [WIDTH-1:0] in_data_i,  // Write data
  output logic                  out_valid_o,// Data available
  input  wire logic             out_ready_i,// Drain accepts
  output logic      [WIDTH-1:0] out_data_o  // Head word
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic [PW:0]      count_next;
  logic             push;
  logic             pop;

  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign count_next  = count_reg + (PW+1)'(push) - (PW+1)'(pop);

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers, occupancy and registered flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)  rd_ptr_reg <= rd_ptr_reg + PW'(1);
      count_reg   <= count_next;
      in_ready_o  <= (count_next != CNT_FULL);
      out_valid_o <= (count_next != '0);
    end
  end
endmodule : cpi2c_fifo

// ============================================================
// Control port top
module cpi2c_control_port (
  input  wire logic        core_clk_i,        // 50 MHz core clock
  input  wire logic        rstn_i,            // Hardware reset, low
  input  wire logic        sw_reset_i,        // Software reset pulse
  input  wire logic        cs_n_i,            // Chip-select pin
  input  wire logic        scl_i,             // Serial clock pin
  input  wire logic        sda_i,             // SDA pin level
  output logic             sda_o,             // SDA drive value
  output logic             sda_oe_o,          // SDA pull-low enable
  output logic             req_n_o,           // Request pin, low
  input  wire logic        mode_wr_i,         // Firmware mode write
  input  wire logic        mode_wr_data_i,    // New mode select
  output logic             port_mode_select_o,// Current mode
  input  wire logic        addr_cfg_wr_i,     // Address config write
  input  wire logic        addr_check_en_i,   // New check enable
  input  wire logic [6:0]  dev_addr_i,        // New device address
  input  wire logic        in_irq_en_i,       // Input full irq enable
  input  wire logic        out_irq_en_i,      // Output empty irq en
  input  wire logic        rej_irq_en_i,      // Reject irq enable
  input  wire logic        out_valid_i,       // DSP output write
  output logic             out_ready_o,       // FIFO has room
  input  wire logic [7:0]  out_data_i,        // DSP output byte
  input  wire logic        in_rd_i,           // DSP reads input
  output logic      [7:0]  in_data_o,         // Input holding
  input  wire logic        ctrl_rd_i,         // DSP reads control
  output logic             input_full_flag_o, // Input full flag
  output logic             output_empty_flag_o,// Output empty flag
  output logic             byte_reject_flag_o,// Reject flag
  output logic             irq2_o,            // Line 2 pulse
  output logic      [15:0] irq2_vec_o,        // Line 2 vector
  output logic             irq3_o             // Line 3 pulse
);
  cpi2c_pkg::cpi2c_state_t state_reg;
  logic       rst_s1_reg, rst_n;
  logic [2:0] scl_sync_reg, sda_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] mode_cnt_reg;
  logic       addr_check_en_reg;
  logic [6:0] dev_addr_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       rw_reg, load_ok_reg, req_block_reg, pend_out_reg;
  logic [7:0] out_hold_reg, fifo_data;
  logic       fifo_valid, hold_pop;
  logic       scl_rise, scl_fall, start_cond, stop_cond, port_on;
  logic       addr_done, addr_match, wr_done, accept, reject;
  logic       ld_after_addr, ld_after_ack, load_shift;
  logic       last_rise, ack_rise, out_evt, in_evt;

  // ==========================================================
  // Reset release and pin synchronisers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Two flops each, then a third on SCL and SDA only for edge finding
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      cs_sync_reg  <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      cs_sync_reg  <= {cs_sync_reg[0], cs_n_i};
    end
  end

  // Edges and bus conditions from synchronised levels
  assign scl_rise   = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall   = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_cond = port_on & scl_sync_reg[1] & scl_sync_reg[2]
                      & ~sda_sync_reg[1] & sda_sync_reg[2];
  assign stop_cond  = scl_sync_reg[1] & scl_sync_reg[2]
                      & sda_sync_reg[1] & ~sda_sync_reg[2];

  // ==========================================================
  // Mode select: strap capture after any reset, firmware write
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_cnt_reg       <= cpi2c_pkg::MODE_LOAD_WAIT;
      port_mode_select_o <= cpi2c_pkg::MODE_I2C;
    end else if (sw_reset_i) begin
      mode_cnt_reg <= cpi2c_pkg::MODE_LOAD_WAIT;
    end else if (mode_cnt_reg != cpi2c_pkg::MODE_LOAD_DONE) begin
      mode_cnt_reg <= mode_cnt_reg - 2'h1;
      if (mode_cnt_reg == 2'h1) begin
        port_mode_select_o <= ~cs_sync_reg[1];
      end
    end else if (mode_wr_i) begin
      port_mode_select_o <= mode_wr_data_i;
    end
  end

  assign port_on = (port_mode_select_o == cpi2c_pkg::MODE_I2C)
                   & (mode_cnt_reg == cpi2c_pkg::MODE_LOAD_DONE)
                   & ~sw_reset_i;

  // Address check settings, cleared at power up
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_check_en_reg <= 1'b0;
      dev_addr_reg      <= cpi2c_pkg::ADDR_ZERO;
    end else if (addr_cfg_wr_i) begin
      addr_check_en_reg <= addr_check_en_i;
      dev_addr_reg      <= dev_addr_i;
    end
  end

  // ==========================================================
  // Protocol events
  assign addr_done  = (state_reg == cpi2c_pkg::ST_ADDR) & scl_fall
                      & (bit_cnt_reg == cpi2c_pkg::BITS_PER_BYTE);
  assign addr_match = ~addr_check_en_reg
                      | (shift_reg[7:1] == dev_addr_reg);
  assign wr_done    = (state_reg == cpi2c_pkg::ST_WR_DATA) & scl_fall
                      & (bit_cnt_reg == cpi2c_pkg::BITS_PER_BYTE);
  assign accept     = wr_done & ~input_full_flag_o;
  assign reject     = wr_done & input_full_flag_o;
  assign ld_after_addr = (state_reg == cpi2c_pkg::ST_ADDR_ACK)
                         & scl_fall & rw_reg;
  assign ld_after_ack  = (state_reg == cpi2c_pkg::ST_RD_ACK)
                         & scl_fall & load_ok_reg;
  assign load_shift = ld_after_addr | ld_after_ack;
  assign last_rise  = (state_reg == cpi2c_pkg::ST_RD_DATA) & scl_rise
                      & (bit_cnt_reg == cpi2c_pkg::LAST_BIT_BEFORE);
  assign ack_rise   = (state_reg == cpi2c_pkg::ST_RD_ACK) & scl_rise;

  // ==========================================================
  // Byte, acknowledge and read-out state machine
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= cpi2c_pkg::ST_IDLE;
      bit_cnt_reg <= cpi2c_pkg::CNT_ZERO;
      shift_reg   <= cpi2c_pkg::BYTE_ZERO;
      rw_reg      <= 1'b0;
      sda_oe_o    <= 1'b0;
      load_ok_reg <= 1'b0;
    end else if (!port_on) begin
      state_reg <= cpi2c_pkg::ST_IDLE;
      sda_oe_o  <= 1'b0;
    end else if (start_cond) begin
      state_reg   <= cpi2c_pkg::ST_ADDR;
      bit_cnt_reg <= cpi2c_pkg::CNT_ZERO;
      sda_oe_o    <= 1'b0;
    end else if (stop_cond && state_reg != cpi2c_pkg::ST_RD_DATA
                 && state_reg != cpi2c_pkg::ST_RD_ACK) begin
      state_reg <= cpi2c_pkg::ST_IDLE;
      sda_oe_o  <= 1'b0;
    end else begin
      case (state_reg)
        cpi2c_pkg::ST_ADDR, cpi2c_pkg::ST_WR_DATA: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + cpi2c_pkg::CNT_ONE;
          end else if (addr_done) begin
            rw_reg    <= shift_reg[0];
            sda_oe_o  <= addr_match;
            state_reg <= addr_match ? cpi2c_pkg::ST_ADDR_ACK
                                    : cpi2c_pkg::ST_IDLE;
          end else if (wr_done) begin
            sda_oe_o  <= accept;
            state_reg <= cpi2c_pkg::ST_WR_ACK;
          end
        end
        cpi2c_pkg::ST_ADDR_ACK, cpi2c_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= cpi2c_pkg::CNT_ZERO;
            if (ld_after_addr) begin
              shift_reg <= out_hold_reg;
              sda_oe_o  <= ~out_hold_reg[7];
              state_reg <= cpi2c_pkg::ST_RD_DATA;
            end else begin
              sda_oe_o  <= 1'b0;
              state_reg <= cpi2c_pkg::ST_WR_DATA;
            end
          end
        end
        cpi2c_pkg::ST_RD_DATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + cpi2c_pkg::CNT_ONE;
            if (last_rise) begin
              load_ok_reg <= ~output_empty_flag_o;
            end
          end else if (scl_fall) begin
            if (bit_cnt_reg == cpi2c_pkg::BITS_PER_BYTE) begin
              sda_oe_o  <= 1'b0;
              state_reg <= cpi2c_pkg::ST_RD_ACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_o  <= ~shift_reg[6];
            end
          end
        end
        cpi2c_pkg::ST_RD_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= cpi2c_pkg::CNT_ZERO;
            load_ok_reg <= 1'b0;
            if (ld_after_ack) begin
              shift_reg <= out_hold_reg;
              sda_oe_o  <= ~out_hold_reg[7];
              state_reg <= cpi2c_pkg::ST_RD_DATA;
            end else begin
              state_reg <= cpi2c_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: only ever pulls low
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) sda_o <= 1'b0;
    else        sda_o <= 1'b0;
  end

  // ==========================================================
  // Output path: FIFO feeds the output holding register
  cpi2c_fifo #(
    .WIDTH (cpi2c_pkg::BYTE_W),
    .DEPTH (cpi2c_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (out_valid_i),
    .in_ready_o  (out_ready_o),
    .in_data_i   (out_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (hold_pop),
    .out_data_o  (fifo_data)
  );

  assign hold_pop = fifo_valid & output_empty_flag_o & ~load_shift;

  // Output holding register and its empty flag
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_hold_reg        <= cpi2c_pkg::BYTE_ZERO;
      output_empty_flag_o <= 1'b1;
    end else if (load_shift) begin
      output_empty_flag_o <= 1'b1;
    end else if (hold_pop) begin
      out_hold_reg        <= fifo_data;
      output_empty_flag_o <= 1'b0;
    end
  end

  // Request pin: held high from last data bit to ack if empty
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_block_reg <= 1'b0;
      req_n_o       <= 1'b1;
    end else begin
      if (last_rise && output_empty_flag_o) begin
        req_block_reg <= 1'b1;
      end else if (ack_rise || !port_on) begin
        req_block_reg <= 1'b0;
      end
      // FIFO refill in the same cycle keeps the request low unless req_block_reg or a last-bit rise while empty holds it high
      req_n_o <= (output_empty_flag_o & ~hold_pop) | req_block_reg
                 | (last_rise & output_empty_flag_o);
    end
  end

  // ==========================================================
  // Input holding register, input full and reject flags
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_data_o         <= cpi2c_pkg::BYTE_ZERO;
      input_full_flag_o <= 1'b0;
    end else if (accept) begin
      in_data_o         <= shift_reg;
      input_full_flag_o <= 1'b1;
    end else if (in_rd_i) begin
      input_full_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      byte_reject_flag_o <= 1'b0;
    end else if (reject) begin
      byte_reject_flag_o <= 1'b1;
    end else if (ctrl_rd_i) begin
      byte_reject_flag_o <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt pulses; output event waits a cycle on collision
  assign in_evt  = accept & in_irq_en_i;
  assign out_evt = load_shift & ~output_empty_flag_o
                   & out_irq_en_i;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq2_o       <= 1'b0;
      irq2_vec_o   <= cpi2c_pkg::VEC_NONE;
      irq3_o       <= 1'b0;
      pend_out_reg <= 1'b0;
    end else begin
      irq3_o <= reject & ~byte_reject_flag_o & rej_irq_en_i;
      if (in_evt) begin
        irq2_o       <= 1'b1;
        irq2_vec_o   <= cpi2c_pkg::VEC_INPUT_FULL;
        pend_out_reg <= pend_out_reg | out_evt;
      end else if (out_evt || pend_out_reg) begin
        irq2_o       <= 1'b1;
        irq2_vec_o   <= cpi2c_pkg::VEC_OUTPUT_EMPTY;
        pend_out_reg <= 1'b0;
      end else begin
        irq2_o <= 1'b0;
      end
    end
  end
endmodule : cpi2c_control_port

// [bench/cpi2c_port_monitor.sv]
// Checker for the control port top, watching its ports only.
// Assumes it is bound into every control port instance.
`timescale 1ns/10ps
// ============================================================
// Port checker
module cpi2c_port_monitor (
  input wire logic        core_clk_i,          // Core clock
  input wire logic        rstn_i,              // Reset, low
  input wire logic        scl_i,               // Serial clock pin
  input wire logic        sda_oe_o,            // SDA pull-low enable
  input wire logic        req_n_o,             // Request pin, low
  input wire logic        mode_wr_i,           // Mode write
  input wire logic        mode_wr_data_i,      // New mode
  input wire logic        port_mode_select_o,  // Current mode
  input wire logic        in_irq_en_i,         // Input irq enable
  input wire logic        out_irq_en_i,        // Output irq enable
  input wire logic        rej_irq_en_i,        // Reject irq enable
  input wire logic        in_rd_i,             // Input read
  input wire logic        ctrl_rd_i,           // Control read
  input wire logic        input_full_flag_o,   // Input full
  input wire logic        output_empty_flag_o, // Output empty
  input wire logic        byte_reject_flag_o,  // Reject flag
  input wire logic        irq2_o,              // Line 2 pulse
  input wire logic [15:0] irq2_vec_o,          // Line 2 vector
  input wire logic        irq3_o               // Line 3 pulse
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Clock seen high on three samples
  sequence s_scl_high;
    scl_i [*3];
  endsequence
  // Reject pulse lasting one cycle
  sequence s_rej_pulse;
    rej_irq_en_i ##1 !irq3_o;
  endsequence
  a_oe_scl_high: assert property (
    s_scl_high |-> $stable(sda_oe_o)) else $error("SDA moved in SCL high");
  a_rej_irq_raise: assert property (
    $rose(byte_reject_flag_o) && rej_irq_en_i |-> ##[0:2] irq3_o)
    else $error("reject rise without line 3");
  a_rej_irq_shape: assert property (irq3_o |-> s_rej_pulse)
    else $error("line 3 pulse malformed");
  a_rej_flag_hold: assert property (
    byte_reject_flag_o && !ctrl_rd_i |=> byte_reject_flag_o)
    else $error("reject flag dropped");
  a_full_flag_hold: assert property (
    input_full_flag_o && !in_rd_i |=> input_full_flag_o)
    else $error("input full dropped");
  a_in_vec_cause: assert property (
    irq2_o && irq2_vec_o == 16'h0006 |-> in_irq_en_i && input_full_flag_o)
    else $error("vector 0006 without cause");
  a_out_vec_cause: assert property (
    irq2_o && irq2_vec_o == 16'h0007 |-> out_irq_en_i)
    else $error("vector 0007 without enable");
  a_req_release: assert property (
    $rose(req_n_o) |-> output_empty_flag_o)
    else $error("request released with byte pending");
  a_mode_write: assert property (
    mode_wr_i |=> port_mode_select_o == $past(mode_wr_data_i))
    else $error("mode write lost");
endmodule : cpi2c_port_monitor

bind cpi2c_control_port cpi2c_port_monitor u_mon (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl_i),
  .sda_oe_o(sda_oe_o), .req_n_o(req_n_o), .mode_wr_i(mode_wr_i),
  .mode_wr_data_i(mode_wr_data_i), .port_mode_select_o(port_mode_select_o),
  .in_irq_en_i(in_irq_en_i), .out_irq_en_i(out_irq_en_i),
  .rej_irq_en_i(rej_irq_en_i), .in_rd_i(in_rd_i), .ctrl_rd_i(ctrl_rd_i),
  .input_full_flag_o(input_full_flag_o),
  .output_empty_flag_o(output_empty_flag_o),
  .byte_reject_flag_o(byte_reject_flag_o), .irq2_o(irq2_o),
  .irq2_vec_o(irq2_vec_o), .irq3_o(irq3_o));

// [bench/cpi2c_host_model.sv]
// Behavioural host mastering the two-wire bus, 160 ns bit slots.
// Assumes the bench resolves SDA from both enables with a pull-up.
`timescale 1ns/10ps
// ============================================================
// Host bus master
module cpi2c_host_model (
  output logic      scl_o,    // Serial clock, idle high
  output logic      sda_oe_o, // High pulls SDA low
  input  wire logic sda_i     // Resolved SDA level
);
  // Idle bus, clock stands high
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  // One bit slot, sampled mid high
  task automatic bit_slot(input logic b, output logic r);
    sda_oe_o = ~b;
    #40 scl_o = 1'b1;
    #40 r = sda_i;
    #40 scl_o = 1'b0;
    #40;
  endtask : bit_slot
  // Start or repeated start
  task automatic start;
    sda_oe_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 sda_oe_o = 1'b1;
    #40 scl_o = 1'b0;
    #40;
  endtask : start
  // Stop condition
  task automatic stop;
    sda_oe_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 sda_oe_o = 1'b0;
    #40;
  endtask : stop
  // Byte out, MSB first, then device ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  // Byte in, then host ack or nack
  task automatic rd_byte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      d[i] = r;
    end
    bit_slot(last, r);
  endtask : rd_byte
endmodule : cpi2c_host_model

// [bench/testbench.sv]
// Self-checking bench for the control port in I2C slave mode.
// Assumes the host model and bound checker are compiled alongside.
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
  end end
// ============================================================
// Bench top
module testbench;
  logic        core_clk_i, rstn_i, sw_reset_i, cs_n_i, scl_i, sda_i;
  logic        sda_o, sda_oe_o, req_n_o, mode_wr_i, mode_wr_data_i;
  logic        port_mode_select_o, addr_cfg_wr_i, addr_check_en_i;
  logic        in_irq_en_i, out_irq_en_i, rej_irq_en_i, out_valid_i;
  logic        out_ready_o, in_rd_i, ctrl_rd_i, input_full_flag_o;
  logic        output_empty_flag_o, byte_reject_flag_o, irq2_o, irq3_o;
  logic        host_oe, ack;
  logic [6:0]  dev_addr_i;
  logic [7:0]  out_data_i, in_data_o, d;
  logic [15:0] irq2_vec_o;
  int          n_mismatch = 0, check_count = 0, n_in = 0, n_out = 0;
  int          n_rej = 0;
  // Open-drain SDA with pull-up
  assign sda_i = ~(host_oe | sda_oe_o);
  cpi2c_host_model host (.scl_o(scl_i), .sda_oe_o(host_oe), .sda_i(sda_i));
  cpi2c_control_port dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .sw_reset_i(sw_reset_i),
    .cs_n_i(cs_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .req_n_o(req_n_o), .mode_wr_i(mode_wr_i),
    .mode_wr_data_i(mode_wr_data_i), .port_mode_select_o(port_mode_select_o),
    .addr_cfg_wr_i(addr_cfg_wr_i), .addr_check_en_i(addr_check_en_i),
    .dev_addr_i(dev_addr_i), .in_irq_en_i(in_irq_en_i),
    .out_irq_en_i(out_irq_en_i), .rej_irq_en_i(rej_irq_en_i),
    .out_valid_i(out_valid_i), .out_ready_o(out_ready_o),
    .out_data_i(out_data_i), .in_rd_i(in_rd_i), .in_data_o(in_data_o),
    .ctrl_rd_i(ctrl_rd_i), .input_full_flag_o(input_full_flag_o),
    .output_empty_flag_o(output_empty_flag_o),
    .byte_reject_flag_o(byte_reject_flag_o), .irq2_o(irq2_o),
    .irq2_vec_o(irq2_vec_o), .irq3_o(irq3_o));
  // 50 MHz clock
  initial core_clk_i = 1'b0;
  always #10 core_clk_i = ~core_clk_i;
  // Interrupt pulse counters
  always @(posedge core_clk_i) begin
    if (irq2_o === 1'b1 && irq2_vec_o === 16'h0006) n_in++;
    if (irq2_o === 1'b1 && irq2_vec_o === 16'h0007) n_out++;
    if (irq3_o === 1'b1) n_rej++;
  end
  // Step to just after the next edge
  task automatic tick;
    @(posedge core_clk_i);
    #1;
  endtask : tick
  // DSP byte into the output FIFO; valid stays up for the next byte
  task automatic dsp_put(input logic [7:0] b);
    out_valid_i = 1'b1;
    out_data_i  = b;
    @(negedge core_clk_i);
    while (!out_ready_o) @(negedge core_clk_i);
    tick;
  endtask : dsp_put
  // Values after reset
  task automatic t_reset;
    `CHK(output_empty_flag_o, 1'b1)
    `CHK(req_n_o, 1'b1)
    `CHK(input_full_flag_o, 1'b0)
    `CHK(port_mode_select_o, 1'b0)
    `CHK(sda_o, 1'b0)
  endtask : t_reset
  // Write accepted, then rejected while full, retried, cleared
  task automatic t_write;
    host.start;
    host.wr_byte({7'h55, 1'b0}, ack);
    `CHK(ack, 1'b1)
    host.wr_byte(8'hA5, ack);
    `CHK(ack, 1'b1)
    `CHK(in_data_o, 8'hA5)
    `CHK(n_in, 1)
    repeat (2) begin
      host.wr_byte(8'h5A, ack);
      `CHK(ack, 1'b0)
    end
    host.stop;
    `CHK(in_data_o, 8'hA5)
    `CHK(byte_reject_flag_o, 1'b1)
    `CHK(n_rej, 1)
    in_rd_i = 1'b1;
    tick;
    in_rd_i = 1'b0;
    ctrl_rd_i = 1'b1;
    tick;
    ctrl_rd_i = 1'b0;
    tick;
    `CHK(input_full_flag_o, 1'b0)
    `CHK(byte_reject_flag_o, 1'b0)
  endtask : t_write
  // Address check on: wrong address ignored, right one served
  task automatic t_addr;
    addr_cfg_wr_i = 1'b1;
    addr_check_en_i = 1'b1;
    dev_addr_i = 7'h2A;
    tick;
    addr_cfg_wr_i = 1'b0;
    host.start;
    host.wr_byte({7'h11, 1'b0}, ack);
    `CHK(ack, 1'b0)
    host.stop;
    host.start;
    host.wr_byte({7'h2A, 1'b0}, ack);
    `CHK(ack, 1'b1)
    host.wr_byte(8'h0F, ack);
    host.stop;
    `CHK(in_data_o, 8'h0F)
    `CHK(n_in, 2)
    in_rd_i = 1'b1;
    tick;
    in_rd_i = 1'b0;
  endtask : t_addr
  // Fill FIFO until refused, host drains it in one continued read
  task automatic t_read;
    for (int i = 0; i < 5; i++) dsp_put(8'(8'h80 + i));
    out_valid_i = 1'b0;
    repeat (3) tick;
    `CHK(out_ready_o, 1'b0)
    `CHK(req_n_o, 1'b0)
    `CHK(output_empty_flag_o, 1'b0)
    host.start;
    host.wr_byte({7'h2A, 1'b1}, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < 5; i++) begin
      host.rd_byte(d, i == 4);
      `CHK(d, 8'(8'h80 + i))
    end
    host.stop;
    `CHK(req_n_o, 1'b1)
    `CHK(output_empty_flag_o, 1'b1)
    `CHK(n_out, 5)
  endtask : t_read
  // Firmware mode change; other mode leaves bus unanswered
  task automatic t_mode;
    mode_wr_i = 1'b1;
    mode_wr_data_i = 1'b1;
    tick;
    mode_wr_i = 1'b0;
    tick;
    `CHK(port_mode_select_o, 1'b1)
    host.start;
    host.wr_byte({7'h2A, 1'b0}, ack);
    `CHK(ack, 1'b0)
    host.stop;
    mode_wr_i = 1'b1;
    mode_wr_data_i = 1'b0;
    tick;
    mode_wr_i = 1'b0;
    tick;
    `CHK(port_mode_select_o, 1'b0)
  endtask : t_mode
  // Software reset relatches mode from chip-select, low then high
  task automatic t_swrst;
    for (int i = 0; i < 2; i++) begin
      cs_n_i = 1'(i);
      sw_reset_i = 1'b1;
      tick;
      sw_reset_i = 1'b0;
      repeat (4) tick;
      `CHK(port_mode_select_o, 1'(1 - i))
    end
  endtask : t_swrst
  // Verdict and end of run
  task automatic summarize;
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // Watchdog, several times the expected run of about 23 us
  initial begin
    #400000;
    n_mismatch++;
    summarize;
  end
  // Main sequence
  initial begin
    {rstn_i, sw_reset_i, mode_wr_i, mode_wr_data_i} = 4'h0;
    {addr_cfg_wr_i, addr_check_en_i, in_rd_i, ctrl_rd_i} = 4'h0;
    {in_irq_en_i, out_irq_en_i, rej_irq_en_i, cs_n_i} = 4'hF;
    {out_valid_i, dev_addr_i, out_data_i} = 16'h0000;
    repeat (12) @(posedge core_clk_i);
    #1 rstn_i = 1'b1;
    repeat (8) tick;
    t_reset;
    t_write;
    t_addr;
    t_read;
    t_mode;
    t_swrst;
    summarize;
  end
endmodule : testbench
